// file: txja_cfg_bank.v
// four-channel tx path and jitter attenuator configuration bank with apb slave
`timescale 1ns/100ps
`include "txja_regs.vh"
module txja_cfg_bank #(
	parameter NCH = 4
) (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [31:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output wire pready,
	output wire pslverr,
	input wire [NCH-1:0] chan_irq_event,
	output wire irq,
	output wire [NCH-1:0] wide_jitter_limit_mode,
	output wire [NCH-1:0] atten_in_tx,
	output wire [NCH-1:0] atten_in_rx,
	output wire [NCH*8-1:0] atten_depth_bits,
	output wire [NCH-1:0] atten_bandwidth_sel,
	output wire [NCH-1:0] tx_power_down,
	output wire [NCH-1:0] line_driver_float,
	output wire [NCH-1:0] tx_data_polarity,
	output wire [NCH-1:0] tx_sample_edge_sel,
	output wire [NCH-1:0] enc_hdb3_b8zs,
	output wire [NCH-1:0] enc_ami,
	output wire [NCH-1:0] enc_bypass_dual_rail,
	output wire [NCH-1:0] driver_fail_monitor_en,
	output wire [NCH*3-1:0] pulse_family,
	output wire [NCH*4-1:0] pulse_template_sel
);
	////////////////////////////////////////////////////////////////
	wire acc = psel & penable;
	wire wr = acc & pwrite;
	wire aligned = (paddr[1:0] == 2'b00) && (paddr[31:10] == 22'h000000);
	wire [7:0] idx = paddr[9:2];
	wire [7:0] jcfg_v [0:NCH-1];
	wire [7:0] txc0_v [0:NCH-1];
	wire [7:0] txc1_v [0:NCH-1];
	wire [NCH-1:0] hit;
	wire [NCH-1:0] hit_jcfg;
	wire [NCH-1:0] hit_txc0;
	wire [NCH-1:0] hit_txc1;
	reg [NCH-1:0] status_q;
	reg [NCH-1:0] mask_q;
	reg [7:0] chind_q;
	assign pready = 1'b1;
	////////////////////////////////////////////////////////////////
	genvar g;
	generate
		for (g = 0; g < NCH; g = g + 1) begin : ch
			wire [31:0] base_w = g * `TXJA_CH_STRIDE;
			wire [7:0] base = base_w[7:0];
			wire h_j = aligned && (idx == (base | `TXJA_IDX_JCFG));
			wire h_0 = aligned && (idx == (base | `TXJA_IDX_TXC0));
			wire h_1 = aligned && (idx == (base | `TXJA_IDX_TXC1));
			assign hit_jcfg[g] = h_j;
			assign hit_txc0[g] = h_0;
			assign hit_txc1[g] = h_1;
			assign hit[g] = h_j | h_0 | h_1;
			txja_chan_cfg u_cfg (
				.pclk(pclk),
				.presetn(presetn),
				.wr_jcfg(wr & h_j),
				.wr_txc0(wr & h_0),
				.wr_txc1(wr & h_1),
				.wdata(pwdata[7:0]),
				.jcfg_q(jcfg_v[g]),
				.txc0_q(txc0_v[g]),
				.txc1_q(txc1_v[g]),
				.wide_jitter_limit_mode(wide_jitter_limit_mode[g]),
				.atten_in_tx(atten_in_tx[g]),
				.atten_in_rx(atten_in_rx[g]),
				.atten_depth_bits(atten_depth_bits[g*8 +: 8]),
				.atten_bandwidth_sel(atten_bandwidth_sel[g]),
				.tx_power_down(tx_power_down[g]),
				.line_driver_float(line_driver_float[g]),
				.tx_data_polarity(tx_data_polarity[g]),
				.tx_sample_edge_sel(tx_sample_edge_sel[g]),
				.enc_hdb3_b8zs(enc_hdb3_b8zs[g]),
				.enc_ami(enc_ami[g]),
				.enc_bypass_dual_rail(enc_bypass_dual_rail[g]),
				.driver_fail_monitor_en(driver_fail_monitor_en[g]),
				.pulse_family(pulse_family[g*3 +: 3]),
				.pulse_template_sel(pulse_template_sel[g*4 +: 4])
			);
		end
	endgenerate
	////////////////////////////////////////////////////////////////
	wire h_chind = aligned && (idx == `TXJA_IDX_CHIND);
	wire h_stat = aligned && (idx == `TXJA_IDX_STATUS);
	wire h_mask = aligned && (idx == `TXJA_IDX_MASK);
	wire h_src = aligned && (idx == `TXJA_IDX_SRC);
	wire mapped = (|hit) | h_chind | h_stat | h_mask | h_src;
	assign pslverr = acc & ~mapped;
	integer i;
	reg [7:0] chind_d;
	// channel flags spread to even bits
	always @* begin
		chind_d = 8'h00;
		for (i = 0; i < NCH; i = i + 1)
			chind_d[2*i] = status_q[i];
	end
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_q <= {NCH{1'b0}};
			mask_q <= {NCH{1'b0}};
			chind_q <= `TXJA_RST_CHIND;
		end else begin
			// set wins over write-one-to-clear
			status_q <= (status_q & ~((wr & h_stat) ? pwdata[NCH-1:0] : {NCH{1'b0}})) | chan_irq_event;
			if (wr & h_mask)
				mask_q <= pwdata[NCH-1:0];
			chind_q <= chind_d;
		end
	end
	assign irq = |(status_q & mask_q);
	////////////////////////////////////////////////////////////////
	// read data registered on the setup cycle, valid at access
	integer k;
	reg [7:0] rd_d;
	always @* begin
		rd_d = 8'h00;
		for (k = 0; k < NCH; k = k + 1) begin
			if (hit_jcfg[k])
				rd_d = jcfg_v[k];
			if (hit_txc0[k])
				rd_d = txc0_v[k];
			if (hit_txc1[k])
				rd_d = txc1_v[k];
		end
		if (h_chind)
			rd_d = chind_q;
		if (h_stat)
			rd_d = {{(8-NCH){1'b0}}, status_q};
		if (h_mask)
			rd_d = {{(8-NCH){1'b0}}, mask_q};
		if (h_src)
			rd_d = {{(8-NCH){1'b0}}, chan_irq_event};
	end
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			prdata <= 32'h00000000;
		else if (psel & ~penable & ~pwrite)
			prdata <= {24'h000000, rd_d};
	end
endmodule

// file: txja_regs.vh
// register map and field constants for the tx path and jitter attenuator config bank
`ifndef TXJA_REGS_VH
`define TXJA_REGS_VH
`define TXJA_IDX_JCFG 8'h01
`define TXJA_IDX_TXC0 8'h02
`define TXJA_IDX_TXC1 8'h03
`define TXJA_IDX_CHIND 8'h80
`define TXJA_IDX_STATUS 8'h90
`define TXJA_IDX_MASK 8'h91
`define TXJA_IDX_SRC 8'h92
`define TXJA_CH_STRIDE 8'h40
`define TXJA_RST_JCFG 8'h00
`define TXJA_RST_TXC0 8'h00
`define TXJA_RST_TXC1 8'h10
`define TXJA_RST_CHIND 8'h00
`define TXJA_MASK_JCFG 8'h3f
`define TXJA_MASK_TXC0 8'h1f
`define TXJA_MASK_TXC1 8'h3f
`define TXJA_BIT_LIMIT 5
`define TXJA_BIT_BW 0
`define TXJA_BIT_TOFF 4
`define TXJA_BIT_INV 3
`define TXJA_BIT_EDGE 2
`define TXJA_BIT_MONOFF 5
`define TXJA_BIT_FLOAT 4
`define TXJA_PL_TX 2'b01
`define TXJA_PL_RX 2'b11
`define TXJA_DP_128 2'b00
`define TXJA_DP_64 2'b01
`define TXJA_DEPTH_128 8'h80
`define TXJA_DEPTH_64 8'h40
`define TXJA_DEPTH_32 8'h20
`define TXJA_MD_HDB3 2'b00
`define TXJA_MD_AMI 2'b01
`define TXJA_PS_USER 2'b11
`define TXJA_PS_E1MAX 4'h1
`define TXJA_PS_T1SHMAX 4'h6
`define TXJA_PS_J1 4'h7
`define TXJA_PS_LH_MSB 2'b10
`define TXJA_WF_E1 3'h0
`define TXJA_WF_T1SH 3'h1
`define TXJA_WF_J1 3'h2
`define TXJA_WF_LH 3'h3
`define TXJA_WF_USER 3'h4
`endif

// file: txja_chan_cfg.v
// one channel of configuration registers with decoded controls
`timescale 1ns/100ps
`include "txja_regs.vh"
module txja_chan_cfg (
	input wire pclk,
	input wire presetn,
	input wire wr_jcfg,
	input wire wr_txc0,
	input wire wr_txc1,
	input wire [7:0] wdata,
	output reg [7:0] jcfg_q,
	output reg [7:0] txc0_q,
	output reg [7:0] txc1_q,
	output wire wide_jitter_limit_mode,
	output wire atten_in_tx,
	output wire atten_in_rx,
	output reg [7:0] atten_depth_bits,
	output wire atten_bandwidth_sel,
	output wire tx_power_down,
	output wire line_driver_float,
	output wire tx_data_polarity,
	output wire tx_sample_edge_sel,
	output wire enc_hdb3_b8zs,
	output wire enc_ami,
	output wire enc_bypass_dual_rail,
	output wire driver_fail_monitor_en,
	output reg [2:0] pulse_family,
	output wire [3:0] pulse_template_sel
);
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			jcfg_q <= `TXJA_RST_JCFG;
			txc0_q <= `TXJA_RST_TXC0;
			txc1_q <= `TXJA_RST_TXC1;
		end else begin
			if (wr_jcfg)
				jcfg_q <= wdata & `TXJA_MASK_JCFG;
			if (wr_txc0)
				txc0_q <= wdata & `TXJA_MASK_TXC0;
			if (wr_txc1)
				txc1_q <= wdata & `TXJA_MASK_TXC1;
		end
	end
	assign wide_jitter_limit_mode = jcfg_q[`TXJA_BIT_LIMIT];
	assign atten_in_tx = (jcfg_q[4:3] == `TXJA_PL_TX);
	assign atten_in_rx = (jcfg_q[4:3] == `TXJA_PL_RX);
	always @* begin
		case (jcfg_q[2:1])
		`TXJA_DP_128: atten_depth_bits = `TXJA_DEPTH_128;
		`TXJA_DP_64: atten_depth_bits = `TXJA_DEPTH_64;
		default: atten_depth_bits = `TXJA_DEPTH_32;
		endcase
	end
	assign atten_bandwidth_sel = jcfg_q[`TXJA_BIT_BW];
	assign tx_power_down = txc0_q[`TXJA_BIT_TOFF];
	// driver floats on power down or float bit
	assign line_driver_float = txc0_q[`TXJA_BIT_TOFF] | txc1_q[`TXJA_BIT_FLOAT];
	assign tx_data_polarity = txc0_q[`TXJA_BIT_INV];
	assign tx_sample_edge_sel = txc0_q[`TXJA_BIT_EDGE];
	assign enc_hdb3_b8zs = (txc0_q[1:0] == `TXJA_MD_HDB3);
	assign enc_ami = (txc0_q[1:0] == `TXJA_MD_AMI);
	assign enc_bypass_dual_rail = txc0_q[1];
	assign driver_fail_monitor_en = ~txc1_q[`TXJA_BIT_MONOFF];
	assign pulse_template_sel = txc1_q[3:0];
	always @* begin
		if (txc1_q[3:2] == `TXJA_PS_USER)
			pulse_family = `TXJA_WF_USER;
		else if (txc1_q[3:2] == `TXJA_PS_LH_MSB)
			pulse_family = `TXJA_WF_LH;
		else if (txc1_q[3:0] <= `TXJA_PS_E1MAX)
			pulse_family = `TXJA_WF_E1;
		else if (txc1_q[3:0] <= `TXJA_PS_T1SHMAX)
			pulse_family = `TXJA_WF_T1SH;
		else if (txc1_q[3:0] == `TXJA_PS_J1)
			pulse_family = `TXJA_WF_J1;
		else
			pulse_family = `TXJA_WF_USER;
	end
endmodule

// file: txja_cfg_bank_asserts.sv
// port assertions for the tx path and jitter config bank
`timescale 1ns/100ps
module txja_cfg_chk #(
	parameter NCH = 4
) (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [31:0] paddr,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire [NCH-1:0] wide_jitter_limit_mode,
	input wire [NCH-1:0] atten_in_tx,
	input wire [NCH-1:0] atten_in_rx,
	input wire [NCH*8-1:0] atten_depth_bits,
	input wire [NCH-1:0] tx_power_down,
	input wire [NCH-1:0] line_driver_float,
	input wire [NCH-1:0] enc_hdb3_b8zs,
	input wire [NCH-1:0] enc_ami,
	input wire [NCH-1:0] enc_bypass_dual_rail,
	input wire [NCH-1:0] driver_fail_monitor_en
);
	wire wr = psel && penable && pwrite;
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	a_place_excl: assert property (!(atten_in_tx[0] && atten_in_rx[0])) else $error("placement in both paths");
	a_mode_onehot: assert property ($onehot({enc_hdb3_b8zs[0], enc_ami[0], enc_bypass_dual_rail[0]}))
		else $error("tx mode not one-hot");
	a_down_floats: assert property (tx_power_down[0] |-> line_driver_float[0]) else $error("power down not floating");
	a_depth_legal: assert property (atten_depth_bits[7:0] inside {8'h80, 8'h40, 8'h20}) else $error("bad depth");
	a_limit_write: assert property (wr && paddr == 32'h4 |=> wide_jitter_limit_mode[0] == $past(pwdata[5]))
		else $error("limit mode not written");
	a_pd_write: assert property (wr && paddr == 32'h8 |=> tx_power_down[0] == $past(pwdata[4]))
		else $error("power down not written");
	a_monoff_write: assert property (wr && paddr == 32'hc |=> driver_fail_monitor_en[0] != $past(pwdata[5]))
		else $error("monitor enable not written");
	a_ind_bits: assert property (psel && penable && !pwrite && paddr == 32'h200 |-> (prdata & 32'hffffffaa) == 0)
		else $error("indication odd bits set");
	c_pd_write: cover property (wr && paddr == 32'h8 && pwdata[4]);
	c_tx_place: cover property (atten_in_tx[0]);
	c_bypass: cover property (enc_bypass_dual_rail[0]);
endmodule
bind txja_cfg_bank txja_cfg_chk #(.NCH(NCH)) i_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
	.prdata, .wide_jitter_limit_mode, .atten_in_tx, .atten_in_rx, .atten_depth_bits, .tx_power_down, .line_driver_float,
	.enc_hdb3_b8zs, .enc_ami, .enc_bypass_dual_rail, .driver_fail_monitor_en);

// file: tb.sv
// self-checking bench for the tx path and jitter config bank
`timescale 1ns/100ps
module tb;
	logic pclk, presetn, psel, penable, pwrite, e;
	logic [31:0] paddr, pwdata, r;
	logic [3:0] ev;
	wire [31:0] prdata, dep;
	wire pready, pslverr, irq;
	wire [3:0] lim, jtx, jrx, bw, pd, flt, pol, edg, hdb, ami, byp, driver_fail_monitor;
	wire [11:0] fam;
	wire [15:0] pls;
	int fail_count, n_checks;
	logic [7:0] j [4], t0 [4], t1 [4];
	txja_cfg_bank i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .chan_irq_event(ev),
		.irq(irq), .wide_jitter_limit_mode(lim), .atten_in_tx(jtx), .atten_in_rx(jrx), .atten_depth_bits(dep),
		.atten_bandwidth_sel(bw), .tx_power_down(pd), .line_driver_float(flt), .tx_data_polarity(pol),
		.tx_sample_edge_sel(edg), .enc_hdb3_b8zs(hdb), .enc_ami(ami), .enc_bypass_dual_rail(byp),
		.driver_fail_monitor_en(driver_fail_monitor), .pulse_family(fam), .pulse_template_sel(pls));
	initial begin
		pclk = 0;
		forever #2.5 pclk = ~pclk;
	end
	task chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("Error %s expected %h seen %h", s, exp, seen);
		end
	endtask
	task print_verdict;
		if (fail_count == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		r = prdata;
		e = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge pclk);
	endtask
	function logic [26:0] dec(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c);
		logic [2:0] f;
		f = c[3:2] == 2'b11 ? 3'h4 : c[3:0] <= 4'h1 ? 3'h0 : c[3:0] <= 4'h6 ? 3'h1 : c[3:0] == 4'h7 ? 3'h2 : 3'h3;
		return {a[5], a[4:3] == 2'b01, a[4:3] == 2'b11, a[2:1] == 2'b00 ? 8'h80 : a[2:1] == 2'b01 ? 8'h40 : 8'h20,
			a[0], b[4], b[4] | c[4], b[3], b[2], b[1:0] == 2'b00, b[1:0] == 2'b01, b[1], !c[5], f, c[3:0]};
	endfunction
	function logic [26:0] obs(input int n);
		return {lim[n], jtx[n], jrx[n], dep[8*n+:8], bw[n], pd[n], flt[n], pol[n], edg[n], hdb[n], ami[n], byp[n],
			driver_fail_monitor[n], fam[3*n+:3], pls[4*n+:4]};
	endfunction
	initial begin
		#50000;
		fail_count++;
		print_verdict;
	end
	initial begin
		{psel, penable, pwrite, presetn} = 0;
		{paddr, pwdata, ev} = 0;
		void'($urandom(24365));
		repeat (10) @(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
		for (int n = 0; n < 4; n++) begin
			chk("decode_reset", obs(n), dec(8'h00, 8'h00, 8'h10));
			for (int k = 1; k < 4; k++) begin
				apb(0, (k + 64 * n) * 4, 0);
				chk("reg_reset", r, k == 3 ? 32'h10 : 32'h0);
			end
		end
		apb(0, 32'h200, 0);
		chk("interrupt_channel_indication_reset", r, 0);
		for (int i = 0; i < 16; i++) begin
			for (int n = 0; n < 4; n++) begin
				j[n] = i == 0 ? 8'hff : 8'($urandom);
				t0[n] = i == 0 ? 8'hff : 8'($urandom);
				t1[n] = i == 0 ? 8'hff : {4'($urandom), 4'(i + n)};
				apb(1, (1 + 64 * n) * 4, j[n]);
				apb(1, (2 + 64 * n) * 4, t0[n]);
				apb(1, (3 + 64 * n) * 4, t1[n]);
			end
			for (int n = 0; n < 4; n++) begin
				chk("decode", obs(n), dec(j[n], t0[n], t1[n]));
				apb(0, (1 + 64 * n) * 4, 0);
				chk("atten_placement", r, j[n] & 8'h3f);
				apb(0, (2 + 64 * n) * 4, 0);
				chk("transmit_config_0", r, t0[n] & 8'h1f);
				apb(0, (3 + 64 * n) * 4, 0);
				chk("transmit_config_1", r, t1[n] & 8'h3f);
			end
		end
		apb(1, 32'h200, 32'hff);
		apb(0, 32'h200, 0);
		chk("interrupt_channel_indication_ro", r, 0);
		apb(0, 32'h3f0, 0);
		chk("unmapped_err", e, 1);
		chk("unmapped_data", r, 0);
		chk("pready", pready, 1);
		for (int n = 0; n < 4; n++) begin
			apb(1, 32'h244, 0);
			ev[n] <= 1;
			@(posedge pclk);
			ev <= 0;
			@(posedge pclk);
			chk("irq_masked", irq, 0);
			apb(0, 32'h240, 0);
			chk("status", r, 1 << n);
			apb(0, 32'h200, 0);
			chk("interrupt_channel_indication", r, 1 << 2 * n);
			apb(1, 32'h244, 1 << n);
			chk("irq_on", irq, 1);
			apb(1, 32'h240, 1 << n);
			chk("irq_clear", irq, 0);
			apb(0, 32'h200, 0);
			chk("interrupt_channel_indication_clear", r, 0);
		end
		print_verdict;
	end
endmodule
